// ### core/gpt_map.svh
// Register offsets, field positions and counting constants of the timer block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH
// Register byte offsets
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_CORE 8'h04
`define OFS_CTRL_B 8'h08
`define OFS_CTRL_AUX2 8'h0c
`define OFS_CTRL_CORE2 8'h10
`define OFS_CNT_A 8'h14
`define OFS_CNT_CORE 8'h18
`define OFS_CNT_B 8'h1c
`define OFS_CNT_AUX2 8'h20
`define OFS_CNT_CORE2 8'h24
`define OFS_CAPTURE_RELOAD_REG 8'h28
`define OFS_STATUS 8'h2c
// Control register fields (same layout for every timer)
`define F_RUN 0
`define F_MODE 2:1
`define F_UD 3
`define F_UDE 4
`define F_PRE 7:5
`define F_FUNC 9:8
`define F_EDGE 11:10
`define F_GATE_LOW 10
`define F_LATCH_SRC 12
`define F_OUT_EN 13
`define F_EXTRA 14
`define F_CAP_EN 15
// Auxiliary timer functions
`define FUNC_NORMAL 2'h0
`define FUNC_RELOAD 2'h1
`define FUNC_CAPTURE 2'h2
// Base divide shifts: 4 clocks per count in module one, 2 in module two
`define FIRST_BASE_SHIFT 4'h2
`define SECOND_BASE_SHIFT 4'h1
// Reset values
`define CTRL_RESET 16'h0000
`define CNT_RESET 16'h0000
`define STATUS_RESET 8'h00
// Status bits: 0..4 wraps of A, core, B, aux2, core2; then captures
`define ST_CAP_A 5
`define ST_CAP_B 6
`define ST_CAP_REL 7
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core/gpt_pkg.sv
// Types shared by the timer block: counting modes and AXI4-Lite carriers.
// Assumes a 32-bit data bus with byte addresses.
package gpt_pkg;
  // Basic counting modes
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_GATED = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_INCREMENTAL = 2'h3
  } mode_t;
  // Master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;
  // Slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
endpackage

// ### core/gpt_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module gpt_sync #(
  parameter int W = 10
) (
  input wire logic clk_i, // Block clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic [W-1:0] d_i, // Raw pin levels
  output logic [W-1:0] q_o // Synchronised levels
);
  logic [W-1:0] meta; // First stage, read only by the second

  // Two flops per bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ### core/gpt_timer16.sv
// One up/down timer register with load and wrap detection.
// Assumes the caller arbitrates loads; a load beats a step.
`include "gpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module gpt_timer16 #(
  parameter int W = 16
) (
  input wire logic clk_i, // Block clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic step_i, // Count one this cycle
  input wire logic down_i, // Count direction, high = down
  input wire logic load_i, // Load request
  input wire logic [W-1:0] load_val_i, // Value to load
  output logic [W-1:0] value_o, // Current count
  output logic wrap_o // Overflow or underflow this cycle
);
  // Wrap is seen in the cycle that the step is taken
  assign wrap_o = step_i && !load_i &&
                  (down_i ? (value_o == '0) : (value_o == {W{1'b1}}));

  // Count register; a load discards the concurrent step
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= `CNT_RESET;
    end else if (ce_i) begin
      if (load_i) begin
        value_o <= load_val_i;
      end else if (step_i) begin
        value_o <= down_i ? value_o - 1'b1 : value_o + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/gpt_top.sv
// Dual-module timer/counter: three timers in module one, two plus a
// capture/reload register in module two, registers over AXI4-Lite.
// Assumes pins are asynchronous and are synchronised here; one clock domain.
`include "gpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Five 16-bit timers, chained within a module
// - Module-one timers: timer, gated, counter, incremental
// - Timer mode counts prescaled system clock
// - Counter mode counts edges on input pin
// - Gated mode counts only while gate active
// - Module one timer/gated modes count at most every 4 clocks
// - Direction from software or direction pin
// - Incremental mode decodes quadrature A/B position
// - Core toggle latch flips on wrap, drives pin
// - Toggle latch can clock either auxiliary timer
// - Aux timer as capture/reload stops counting
// - Aux input pin captures core count
// - Core reloaded from aux by pin/latch edge
// - Alternate reloads give continuous PWM
// - Module two timer/gated modes count at most every 2 clocks
// - Module two: prescaled or external clock, direction
// - Second toggle latch clocks aux, drives pin
// - Core2 wraps clock compare unit, reload core2
// - Capture pin latches aux2; optional clear
// - Capture also from core count/direction inputs
// - Aux2 direction is software only
module gpt_top #(
  parameter int DIV_W = 10 // Prescaler counter width
) (
  input wire logic CLK_I, // 25 MHz block clock
  input wire logic RESETN_I, // Asynchronous reset, active low
  input wire logic CE_I, // Clock enable, freezes all state but the reset synchroniser when low
  input wire gpt_pkg::axil_req_t AXI_REQ_I, // AXI4-Lite master signals
  output gpt_pkg::axil_rsp_t AXI_RSP_O, // AXI4-Lite slave signals
  input wire logic [2:0] FIRST_IN_I, // Count/gate inputs of A, core, B
  input wire logic [2:0] FIRST_DIR_I, // Direction inputs of A, core, B
  input wire logic AUX2_IN_I, // Count input of second aux timer
  input wire logic CORE2_IN_I, // Count/gate input of second core timer
  input wire logic CORE2_DIR_I, // Direction input of second core timer
  input wire logic CAPTURE_PIN_I, // Capture trigger pin
  output logic FIRST_TOGGLE_O, // First core toggle latch output pin
  output logic SECOND_TOGGLE_O, // Second core toggle latch output pin
  output logic EXT_CMP_CLK_O // Second core wrap pulse for compare unit
);
  import gpt_pkg::*;

  // Reset release chain
  logic rst_meta; // First reset flop
  logic rst_n; // Synchronised reset used everywhere

  // Reset asserts at once, releases after two edges
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // True when the prescaler reaches the end of a 2^(base+pre) period
  function automatic logic pre_hit(input logic [DIV_W-1:0] div, input logic [2:0] pre,
                                   input logic [3:0] base);
    logic [DIV_W-1:0] mask;
    mask = ({{(DIV_W-1){1'b0}}, 1'b1} << (base + {1'b0, pre})) - 1'b1;
    return (div & mask) == mask;
  endfunction

  // Edge select: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic prev, input logic now, input logic [1:0] sel);
    return (sel[0] && !prev && now) || (sel[1] && prev && !now);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // Pin synchronisation: 0-2 first inputs, 3-5 first directions, 6 aux2,
  // 7 core2, 8 core2 direction, 9 capture pin
  logic [9:0] pin; // Synchronised pins
  logic [9:0] pin_prev; // Pins one cycle earlier, for edges

  gpt_sync #(.W(10)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .ce_i(CE_I),
    .d_i({CAPTURE_PIN_I, CORE2_DIR_I, CORE2_IN_I, AUX2_IN_I, FIRST_DIR_I, FIRST_IN_I}),
    .q_o(pin)
  );

  // Bus side state
  logic aw_held; // Write address accepted
  logic w_held; // Write data accepted
  logic [7:0] aw_addr; // Held write address
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held byte strobes
  logic bvalid; // Write response pending
  logic [1:0] bresp; // Write response code
  logic rvalid; // Read response pending
  logic [31:0] rdata; // Read data
  logic [1:0] rresp; // Read response code
  logic wr_en; // Write takes effect this cycle

  // Block registers
  logic [15:0] ctrl [5]; // Control of A, core, B, aux2, core2
  logic [15:0] capture_reload_reg; // Capture/reload register
  logic [7:0] status; // Sticky event flags
  logic [DIV_W-1:0] div; // Free-running prescaler
  logic latch1; // First core toggle latch
  logic latch1_prev; // Latch one cycle earlier
  logic latch2; // Second core toggle latch
  logic latch2_prev; // Latch one cycle earlier

  // Timer cell connections
  logic [15:0] cnt [5]; // Counts
  logic [4:0] step; // Count strobes
  logic [4:0] down; // Directions
  logic [4:0] load; // Load strobes
  logic [15:0] load_val [5]; // Load values
  logic [4:0] wrap; // Wrap pulses
  logic [4:0] sw_wr; // Software writes to counts
  logic [2:0] aux_ev; // Capture/reload trigger per first timer
  logic [2:0] cap1; // Capture into A or B (index 1 unused)
  logic [2:0] rel1; // Reload request from A or B (index 1 unused)
  logic cap2; // Capture into capture/reload register

  // Handshakes stall while a response waits
  assign AXI_RSP_O.awready = !aw_held && !bvalid;
  assign AXI_RSP_O.wready = !w_held && !bvalid;
  assign AXI_RSP_O.bvalid = bvalid;
  assign AXI_RSP_O.bresp = bresp;
  assign AXI_RSP_O.arready = !rvalid;
  assign AXI_RSP_O.rvalid = rvalid;
  assign AXI_RSP_O.rdata = rdata;
  assign AXI_RSP_O.rresp = rresp;
  assign wr_en = aw_held && w_held && !bvalid;

  // Address and data taken in either order, held until both are here
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (CE_I) begin
      if (AXI_REQ_I.awvalid && AXI_RSP_O.awready) begin
        aw_held <= 1'b1;
        aw_addr <= AXI_REQ_I.awaddr;
      end else if (wr_en) begin
        aw_held <= 1'b0;
      end
      if (AXI_REQ_I.wvalid && AXI_RSP_O.wready) begin
        w_held <= 1'b1;
        w_data <= AXI_REQ_I.wdata;
        w_strb <= AXI_REQ_I.wstrb;
      end else if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (CE_I) begin
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= (aw_addr <= `OFS_STATUS && aw_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (AXI_REQ_I.bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address; upper bits read as zero
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (CE_I) begin
      if (AXI_REQ_I.arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        unique case (AXI_REQ_I.araddr)
          `OFS_CTRL_A: rdata <= {16'h0000, ctrl[0]};
          `OFS_CTRL_CORE: rdata <= {16'h0000, ctrl[1]};
          `OFS_CTRL_B: rdata <= {16'h0000, ctrl[2]};
          `OFS_CTRL_AUX2: rdata <= {16'h0000, ctrl[3]};
          `OFS_CTRL_CORE2: rdata <= {16'h0000, ctrl[4]};
          `OFS_CNT_A: rdata <= {16'h0000, cnt[0]};
          `OFS_CNT_CORE: rdata <= {16'h0000, cnt[1]};
          `OFS_CNT_B: rdata <= {16'h0000, cnt[2]};
          `OFS_CNT_AUX2: rdata <= {16'h0000, cnt[3]};
          `OFS_CNT_CORE2: rdata <= {16'h0000, cnt[4]};
          `OFS_CAPTURE_RELOAD_REG: rdata <= {16'h0000, capture_reload_reg};
          `OFS_STATUS: rdata <= {24'h00_0000, status};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (AXI_REQ_I.rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Control registers; all timers stopped after reset
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 5; k++) begin
        ctrl[k] <= `CTRL_RESET;
      end
    end else if (CE_I && wr_en) begin
      for (int k = 0; k < 5; k++) begin
        if (aw_addr == `OFS_CTRL_A + 8'(4 * k)) begin
          ctrl[k] <= merge16(ctrl[k], w_data, w_strb);
        end
      end
    end
  end

  // Software count writes load the timer cells
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      sw_wr[k] = wr_en && (aw_addr == `OFS_CNT_A + 8'(4 * k));
    end
  end

  // Prescaler and edge history
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
      pin_prev <= 10'h000;
      latch1_prev <= 1'b0;
      latch2_prev <= 1'b0;
    end else if (CE_I) begin
      div <= div + 1'b1;
      pin_prev <= pin;
      latch1_prev <= latch1;
      latch2_prev <= latch2;
    end
  end

  // Module one: A, core and B share one structure
  for (genvar i = 0; i < 3; i++) begin : g_first
    logic [15:0] c; // This timer's control
    logic is_aux; // A or B
    logic src_now; // Selected event source level
    logic src_prev; // Its previous level
    logic tick; // Prescaled clock strobe
    logic qa; // Quadrature edge on A
    logic qb; // Quadrature edge on B
    logic q_up; // Quadrature says up
    logic halted; // Aux timer serving the core
    assign c = ctrl[i];
    assign is_aux = (i != 1);
    // Aux timers may take the core toggle latch as their count source
    assign src_now = (is_aux && c[`F_LATCH_SRC]) ? latch1 : pin[i];
    assign src_prev = (is_aux && c[`F_LATCH_SRC]) ? latch1_prev : pin_prev[i];
    assign tick = pre_hit(div, c[`F_PRE], `FIRST_BASE_SHIFT);
    assign qa = pin[i] ^ pin_prev[i];
    assign qb = pin[3 + i] ^ pin_prev[3 + i];
    // A leads B when counting up; simultaneous edges are a glitch and skipped
    assign q_up = qa ? (pin[i] != pin[3 + i]) : (pin[i] == pin[3 + i]);
    assign halted = is_aux && (c[`F_FUNC] != `FUNC_NORMAL);
    assign aux_ev[i] = edge_hit(src_prev, src_now, c[`F_EDGE]);
    assign cap1[i] = is_aux && c[`F_FUNC] == `FUNC_CAPTURE && aux_ev[i];
    assign rel1[i] = is_aux && c[`F_FUNC] == `FUNC_RELOAD && aux_ev[i];

    // Count strobe and direction per mode
    always_comb begin
      step[i] = 1'b0;
      down[i] = c[`F_UD] ^ (c[`F_UDE] & pin[3 + i]);
      if (c[`F_RUN] && !halted) begin
        unique case (mode_t'(c[`F_MODE]))
          MODE_TIMER: step[i] = tick;
          MODE_GATED: step[i] = tick && (pin[i] != c[`F_GATE_LOW]);
          MODE_COUNTER: step[i] = aux_ev[i];
          MODE_INCREMENTAL: begin
            step[i] = qa ^ qb;
            down[i] = !q_up ^ c[`F_UD];
          end
        endcase
      end
    end

    gpt_timer16 u_tmr (
      .clk_i(CLK_I),
      .rst_n_i(rst_n),
      .ce_i(CE_I),
      .step_i(step[i]),
      .down_i(down[i]),
      .load_i(load[i]),
      .load_val_i(load_val[i]),
      .value_o(cnt[i]),
      .wrap_o(wrap[i])
    );
  end

  // Module-one loads: aux captures the core, core reloads from an aux.
  // With a latch source on opposite edges A and B alternate, giving PWM.
  always_comb begin
    load[0] = sw_wr[0] || cap1[0];
    load_val[0] = sw_wr[0] ? w_data[15:0] : cnt[1];
    load[2] = sw_wr[2] || cap1[2];
    load_val[2] = sw_wr[2] ? w_data[15:0] : cnt[1];
    load[1] = sw_wr[1] || rel1[0] || rel1[2];
    if (sw_wr[1]) begin
      load_val[1] = w_data[15:0];
    end else if (rel1[0]) begin
      load_val[1] = cnt[0];
    end else begin
      load_val[1] = cnt[2];
    end
  end

  // Module two, core and aux timers: prescaled, gated or external source
  logic tick2; // Prescaled strobe of core2
  logic tick5; // Prescaled strobe of aux2
  logic src5_now; // Aux2 source level
  logic src5_prev; // Its previous level
  assign tick2 = pre_hit(div, ctrl[4][`F_PRE], `SECOND_BASE_SHIFT);
  assign tick5 = pre_hit(div, ctrl[3][`F_PRE], `SECOND_BASE_SHIFT);
  assign src5_now = ctrl[3][`F_LATCH_SRC] ? latch2 : pin[6];
  assign src5_prev = ctrl[3][`F_LATCH_SRC] ? latch2_prev : pin_prev[6];

  // Core2 strobe; direction from software or its pin
  always_comb begin
    step[4] = 1'b0;
    down[4] = ctrl[4][`F_UD] ^ (ctrl[4][`F_UDE] & pin[8]);
    if (ctrl[4][`F_RUN]) begin
      unique case (mode_t'(ctrl[4][`F_MODE]))
        MODE_TIMER: step[4] = tick2;
        MODE_GATED: step[4] = tick2 && (pin[7] != ctrl[4][`F_GATE_LOW]);
        default: step[4] = edge_hit(pin_prev[7], pin[7], ctrl[4][`F_EDGE]);
      endcase
    end
  end

  // Aux2 strobe; no direction pin exists for it
  always_comb begin
    step[3] = 1'b0;
    down[3] = ctrl[3][`F_UD];
    if (ctrl[3][`F_RUN]) begin
      unique case (mode_t'(ctrl[3][`F_MODE]))
        MODE_TIMER: step[3] = tick5;
        MODE_GATED: step[3] = tick5 && (pin[6] != ctrl[3][`F_GATE_LOW]);
        default: step[3] = edge_hit(src5_prev, src5_now, ctrl[3][`F_EDGE]);
      endcase
    end
  end

  // Capture trigger: own pin, or the first core's count and direction inputs
  always_comb begin
    if (ctrl[3][`F_FUNC] == 2'h0) begin
      cap2 = edge_hit(pin_prev[9], pin[9], ctrl[3][`F_EDGE]);
    end else begin
      cap2 = (ctrl[3][8] && edge_hit(pin_prev[1], pin[1], ctrl[3][`F_EDGE])) ||
             (ctrl[3][9] && edge_hit(pin_prev[4], pin[4], ctrl[3][`F_EDGE]));
    end
    cap2 = cap2 && ctrl[3][`F_CAP_EN];
  end

  // Module-two loads: optional clear after capture, reload of core2 on wrap
  always_comb begin
    load[3] = sw_wr[3] || (cap2 && ctrl[3][`F_EXTRA]);
    load_val[3] = sw_wr[3] ? w_data[15:0] : `CNT_RESET;
    load[4] = sw_wr[4] || (wrap[4] && ctrl[4][`F_EXTRA]);
    load_val[4] = sw_wr[4] ? w_data[15:0] : capture_reload_reg;
  end

  for (genvar j = 3; j < 5; j++) begin : g_second
    gpt_timer16 u_tmr (
      .clk_i(CLK_I),
      .rst_n_i(rst_n),
      .ce_i(CE_I),
      .step_i(step[j]),
      .down_i(down[j]),
      .load_i(load[j]),
      .load_val_i(load_val[j]),
      .value_o(cnt[j]),
      .wrap_o(wrap[j])
    );
  end

  // Capture/reload register; a capture beats a concurrent software write
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      capture_reload_reg <= `CNT_RESET;
    end else if (CE_I) begin
      if (cap2) begin
        capture_reload_reg <= cnt[3];
      end else if (wr_en && aw_addr == `OFS_CAPTURE_RELOAD_REG) begin
        capture_reload_reg <= merge16(capture_reload_reg, w_data, w_strb);
      end
    end
  end

  // Toggle latches flip on every wrap of their core timer
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      latch1 <= 1'b0;
      latch2 <= 1'b0;
    end else if (CE_I) begin
      latch1 <= latch1 ^ wrap[1];
      latch2 <= latch2 ^ wrap[4];
    end
  end

  // Output pins; registered so that they never glitch
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      FIRST_TOGGLE_O <= 1'b0;
      SECOND_TOGGLE_O <= 1'b0;
      EXT_CMP_CLK_O <= 1'b0;
    end else if (CE_I) begin
      FIRST_TOGGLE_O <= (latch1 ^ wrap[1]) && ctrl[1][`F_OUT_EN];
      SECOND_TOGGLE_O <= (latch2 ^ wrap[4]) && ctrl[4][`F_OUT_EN];
      EXT_CMP_CLK_O <= wrap[4];
    end
  end

  // Sticky flags: write one clears, a same-cycle event wins
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      status <= `STATUS_RESET;
    end else if (CE_I) begin
      status <= (status & ~((wr_en && aw_addr == `OFS_STATUS && w_strb[0]) ? w_data[7:0] : 8'h00))
                | {cap2, cap1[2], cap1[0], wrap};
    end
  end
endmodule
`default_nettype wire

// ### tb/gpt_top_properties.sv
// Checker for the bus answers and wrap outputs of the timer block.
// Assumes it is bound to gpt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpt_top_props (
  input wire logic CLK_I, // Block clock
  input wire logic RESETN_I, // Reset, active low
  input wire logic CE_I, // Clock enable
  input wire gpt_pkg::axil_req_t AXI_REQ_I, // Bus requests
  input wire gpt_pkg::axil_rsp_t AXI_RSP_O, // Bus answers
  input wire logic FIRST_TOGGLE_O, // First toggle pin
  input wire logic SECOND_TOGGLE_O, // Second toggle pin
  input wire logic EXT_CMP_CLK_O // Core2 wrap pulse
);
  logic bv_q; // Write answer one cycle ago
  logic wr_near; // Pins may move around a write
  logic ar_take; // Read request taken
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // Write answer one cycle back, pins lag a control write
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bv_q <= 1'b0;
    end else begin
      bv_q <= AXI_RSP_O.bvalid;
    end
  end
  assign wr_near = AXI_RSP_O.bvalid || bv_q;
  assign ar_take = AXI_REQ_I.arvalid && AXI_RSP_O.arready;
  // Both halves of a write taken at one edge
  sequence s_wr_take;
    AXI_REQ_I.awvalid && AXI_RSP_O.awready && AXI_REQ_I.wvalid && AXI_RSP_O.wready;
  endsequence
  sequence s_wr_answer;
    ##2 AXI_RSP_O.bvalid;
  endsequence
  a_reset_clear: assert property ($rose(RESETN_I) |->
    !FIRST_TOGGLE_O && !SECOND_TOGGLE_O && !EXT_CMP_CLK_O) else $error("outputs not clear");
  a_write_answer: assert property (s_wr_take |-> s_wr_answer)
    else $error("write answer late");
  a_read_answer: assert property (ar_take |=> AXI_RSP_O.rvalid)
    else $error("read answer late");
  a_bad_addr: assert property (ar_take && AXI_REQ_I.araddr > 8'h2c |=>
    AXI_RSP_O.rresp == 2'h2 && AXI_RSP_O.rdata == 32'h0) else $error("bad read answer");
  a_read_refuse: assert property (AXI_RSP_O.rvalid |-> !AXI_RSP_O.arready)
    else $error("read taken while busy");
  a_write_done: assert property (AXI_RSP_O.bvalid && AXI_REQ_I.bready |=>
    !AXI_RSP_O.bvalid) else $error("write answer stuck");
  a_cmp_pulse: assert property (EXT_CMP_CLK_O |=> !EXT_CMP_CLK_O || !CE_I)
    else $error("wrap pulse too long");
  a_toggle2_cause: assert property ($changed(SECOND_TOGGLE_O) |->
    EXT_CMP_CLK_O || $past(EXT_CMP_CLK_O) || wr_near) else $error("toggle without wrap");
  a_toggle1_space: assert property ($changed(FIRST_TOGGLE_O) && !wr_near |=>
    ($stable(FIRST_TOGGLE_O) || wr_near) [*3]) else $error("wraps too close");
endmodule
bind gpt_top gpt_top_props gpt_top_props_i (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .AXI_REQ_I(AXI_REQ_I),
  .AXI_RSP_O(AXI_RSP_O), .FIRST_TOGGLE_O(FIRST_TOGGLE_O),
  .SECOND_TOGGLE_O(SECOND_TOGGLE_O), .EXT_CMP_CLK_O(EXT_CMP_CLK_O)
);
`default_nettype wire

// ### tb/quad_sensor.sv
// Quadrature position sensor feeding the core count and direction pins.
// Assumes the bench asks for one edge at a time.
`timescale 1ns/1ps
`default_nettype none
module quad_sensor (
  input wire logic clk_i, // Bench clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic step_i, // Move one edge
  input wire logic fwd_i, // High moves forward, track A leads
  output logic qa_o, // Track A
  output logic qb_o // Track B
);
  logic [1:0] ph; // Position within one Gray cycle
  // Only one track changes per step, as a real encoder does
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 2'h0;
    end else if (step_i) begin
      ph <= fwd_i ? ph + 2'h1 : ph - 2'h1;
    end
  end
  assign qa_o = ph[1] ^ ph[0];
  assign qb_o = ph[1];
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench: AXI4-Lite register access plus pin stimulus.
// Assumes the block's map header and package are compiled first.
`include "gpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpt_pkg::*;
  logic clk = 1'b0; // 25 MHz clock
  logic rstn = 1'b0; // Reset, active low
  axil_req_t req = '0; // Bus master side
  axil_rsp_t rsp; // Bus slave side
  logic [2:0] fin = 3'h0; // Count inputs of A and B (bit 1 unused, core takes track A)
  logic qstep = 1'b0; // Sensor step request
  logic qfwd = 1'b1; // Sensor direction
  logic qa, qb, t1, t2, cmp; // Sensor tracks and block outputs
  logic [31:0] d; // Read data
  logic [1:0] r; // Read response
  int bad_count = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  gpt_top gpt_top_i (.CLK_I(clk), .RESETN_I(rstn), .CE_I(1'b1), .AXI_REQ_I(req),
    .AXI_RSP_O(rsp), .FIRST_IN_I({fin[2], qa, fin[0]}), .FIRST_DIR_I({1'b0, qb, 1'b0}),
    .AUX2_IN_I(1'b0), .CORE2_IN_I(1'b0), .CORE2_DIR_I(1'b0), .CAPTURE_PIN_I(1'b0),
    .FIRST_TOGGLE_O(t1), .SECOND_TOGGLE_O(t2), .EXT_CMP_CLK_O(cmp));
  quad_sensor quad_sensor_i (.clk_i(clk), .rst_n_i(rstn), .step_i(qstep), .fwd_i(qfwd),
    .qa_o(qa), .qb_o(qb));
  // Range compare; unknown fails
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h want=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Write: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    {req.awvalid, req.wvalid, req.bready, req.awaddr} <= {3'h7, a};
    {req.wdata, req.wstrb} <= {16'h0000, v, 4'hf};
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {req.arvalid, req.rready, req.araddr} <= {2'h3, a};
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask
  // Read, expect OKAY and data in range
  task automatic rc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    rd(a);
    chk({30'h0, r}, 32'h0, 32'h0);
    chk(d, lo, hi);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) fin[0] <= 1'b1;
      repeat (8) @(posedge clk);
      fin[0] <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic quad(input logic f, input int n);
    repeat (n) begin
      @(posedge clk) {qfwd, qstep} <= {f, 1'b1};
      @(posedge clk) qstep <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, well beyond the ~850 cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) rc(8'(4 * i), 32'h0, 32'h0);
    rd(8'h30);
    chk({d[31:2], r}, 32'h2, 32'h2);
    // Run both core timers at the finest rate, then stop them
    wr(`OFS_CTRL_CORE2, 16'h0001);
    wr(`OFS_CTRL_CORE, 16'h0001);
    repeat (400) @(posedge clk);
    wr(`OFS_CTRL_CORE, 16'h0000);
    wr(`OFS_CTRL_CORE2, 16'h0000);
    rc(`OFS_CNT_CORE, 32'd96, 32'd108);
    rc(`OFS_CNT_CORE2, 32'd196, 32'd216);
    // Count down from zero: first step underflows, flips the latch
    for (int k = 0; k < 2; k++) begin
      wr(k ? `OFS_CNT_CORE2 : `OFS_CNT_CORE, 16'h0000);
      wr(k ? `OFS_CTRL_CORE2 : `OFS_CTRL_CORE, 16'h2009);
      repeat (20) @(posedge clk);
      chk({31'h0, k ? t2 : t1}, 32'h1, 32'h1);
      wr(k ? `OFS_CTRL_CORE2 : `OFS_CTRL_CORE, 16'h2008);
      rc(`OFS_STATUS, k ? 32'h10 : 32'h2, k ? 32'h10 : 32'h2);
      wr(`OFS_STATUS, 16'h00ff);
      rc(`OFS_STATUS, 32'h0, 32'h0);
    end
    wr(`OFS_CNT_A, 16'h0000);
    wr(`OFS_CTRL_A, 16'h0405);
    pulse(5);
    rc(`OFS_CNT_A, 32'h5, 32'h5);
    // Rising pin edge reloads the stopped core from A; A holds
    wr(`OFS_CTRL_A, 16'h0501);
    wr(`OFS_CNT_A, 16'h1234);
    pulse(1);
    rc(`OFS_CNT_CORE, 32'h1234, 32'h1234);
    rc(`OFS_CNT_A, 32'h1234, 32'h1234);
    wr(`OFS_CNT_CORE, 16'h0000);
    wr(`OFS_CTRL_CORE, 16'h0007);
    quad(1'b1, 8);
    quad(1'b0, 3);
    rc(`OFS_CNT_CORE, 32'h5, 32'h5);
    results();
  end
endmodule
`default_nettype wire
